// ==== cfr_pkg.sv ====
package cfr_pkg;

  localparam int IDX_W = 7;
  localparam int DATA_W = 16;
  localparam int NUM_FLAGS = 3;

  // register indices
  localparam logic [6:0] IDX_FEAT_CTRL_TWO = 7'h6c;
  localparam logic [6:0] IDX_TEST_CTRL = 7'h6e;
  localparam logic [6:0] IDX_SHORT_STATUS = 7'h70;
  localparam logic [6:0] IDX_VENDOR_ONE = 7'h7c;
  localparam logic [6:0] IDX_VENDOR_TWO = 7'h7e;

  // feature control two field positions
  localparam int POS_TEST_BIT_TOP = 15;
  localparam int POS_STARTUP_TEST = 13;
  localparam int POS_ADC_FILTER_EN = 12;
  localparam int POS_AVERAGING_TEST = 10;
  localparam int POS_LOW_POWER_SEL = 4;
  localparam int POS_EVENT_TEST = 0;

  // writable bits of feature control two; the rest read zero
  localparam logic [15:0] FEAT_CTRL_TWO_MASK = 16'hfc37;
  localparam logic [15:0] FEAT_CTRL_TWO_RESET = 16'h0000;

  // test control field
  localparam int TEST_MODE_W = 7;

  // short circuit flag positions, flag index 0 is left, 1 right, 2 reference driver
  localparam int POS_LEFT_SHORT = 15;
  localparam int POS_RIGHT_SHORT = 14;
  localparam int POS_REF_SHORT = 13;
  localparam logic [2:0] SHORT_FLAGS_RESET = 3'h0;

  // low power select encodings
  typedef enum logic [1:0] {
    CFR_LP_NONE = 2'h0,
    CFR_LP_CODEC = 2'h1,
    CFR_LP_PLL = 2'h2,
    CFR_LP_BOTH = 2'h3
  } cfr_low_power_e;

endpackage

// ==== cfr_flag_if.sv ====
`timescale 1ns/1ns
`default_nettype none
interface cfr_flag_if;
  logic [2:0] clr;
  logic [2:0] set;
  logic [2:0] flags;

  modport owner (input clr, output set, output flags);
  modport user (output clr, input set, input flags);
endinterface
`default_nettype wire

// ==== cfr_short_flags.sv ====
`timescale 1ns/1ns
`default_nettype none
module cfr_short_flags
(
  input wire logic clk,
  input wire logic srst,
  input wire logic [2:0] clip_raw,
  cfr_flag_if.owner fl
);

  logic [2:0] sync1_r;
  logic [2:0] sync2_r;
  logic [2:0] flags_r;
  logic [2:0] flags_nxt;

  // clip levels come from the analog output stages, so each is synchronised first
  genvar g;
  generate
    for (g = 0; g < cfr_pkg::NUM_FLAGS; g++)
    begin : g_flag
      always_ff @(posedge clk)
      begin
        sync1_r[g] <= clip_raw[g];
        sync2_r[g] <= sync1_r[g];
      end
      // set wins over a clear in the same cycle so no event is lost
      always_comb
      begin
        flags_nxt[g] = (flags_r[g] & ~fl.clr[g]) | sync2_r[g];
      end
    end
  endgenerate

  always_ff @(posedge clk)
  begin
    if (srst)
      flags_r <= cfr_pkg::SHORT_FLAGS_RESET;
    else
      flags_r <= flags_nxt;
  end

  assign fl.set = sync2_r;
  assign fl.flags = flags_r;

endmodule
`default_nettype wire

// ==== cfr_regs.sv ====
`timescale 1ns/1ns
`default_nettype none
module cfr_regs
#(
  parameter int N_STAGES = 4,
  parameter logic [15:0] VENDOR_ID_ONE = 16'h1234, // arbitrary value
  parameter logic [15:0] VENDOR_ID_TWO = 16'h5678 // arbitrary value
)
(
  input wire logic SYS_CLK,
  input wire logic SRST,
  input wire logic [6:0] REG_INDEX,
  input wire logic REG_WR,
  input wire logic REG_RD,
  input wire logic [15:0] REG_WDATA,
  output logic [15:0] REG_RDATA,
  output logic REG_RVALID,
  input wire logic LEFT_CLIP_SIGNAL,
  input wire logic RIGHT_CLIP_SIGNAL,
  input wire logic GROUND_CLIP_SIGNAL,
  input wire logic VENDOR_TEST_MODE,
  input wire logic [N_STAGES-1:0] INPUT_STAGE_USED,
  input wire logic ADC_POWERED,
  input wire logic DAC_POWERED,
  input wire logic ADC_RATE_44K_FAMILY,
  input wire logic DAC_RATE_44K_FAMILY,
  output logic ADC_FILTER_ENABLE,
  output logic [N_STAGES-1:0] INPUT_STAGE_POWER,
  output logic PLL_POWER,
  output logic [6:0] TEST_MODE_FIELD,
  output logic [2:0] SHORT_FLAGS
);

  if (N_STAGES < 1 || N_STAGES > 16)
  begin : g_bad_stages
    $error("N_STAGES must be between 1 and 16");
  end

  cfr_flag_if fl ();

  cfr_short_flags u_flags (
    .clk(SYS_CLK),
    .srst(SRST),
    .clip_raw({GROUND_CLIP_SIGNAL, RIGHT_CLIP_SIGNAL, LEFT_CLIP_SIGNAL}),
    .fl(fl)
  );

  // register decode
  logic wr_feat;
  logic wr_test;
  logic wr_short;
  assign wr_feat = REG_WR && (REG_INDEX == cfr_pkg::IDX_FEAT_CTRL_TWO);
  assign wr_test = REG_WR && (REG_INDEX == cfr_pkg::IDX_TEST_CTRL);
  assign wr_short = REG_WR && (REG_INDEX == cfr_pkg::IDX_SHORT_STATUS);

  // write one clears, zero leaves the flag alone
  always_comb
  begin
    fl.clr = 3'h0;
    if (wr_short)
      fl.clr = {REG_WDATA[cfr_pkg::POS_REF_SHORT],
                REG_WDATA[cfr_pkg::POS_RIGHT_SHORT],
                REG_WDATA[cfr_pkg::POS_LEFT_SHORT]};
  end

  // feature control two
  logic [15:0] feat_r;
  logic [15:0] feat_nxt;
  // test fields are stored as written; the host keeps them zero
  always_comb
  begin
    feat_nxt = feat_r;
    if (wr_feat)
      feat_nxt = REG_WDATA & cfr_pkg::FEAT_CTRL_TWO_MASK;
  end
  always_ff @(posedge SYS_CLK)
  begin
    if (SRST)
      feat_r <= cfr_pkg::FEAT_CTRL_TWO_RESET;
    else
      feat_r <= feat_nxt;
  end

  logic [1:0] low_power_select;
  logic adc_filter_bit;
  assign low_power_select = feat_r[cfr_pkg::POS_LOW_POWER_SEL +: 2];
  assign adc_filter_bit = feat_r[cfr_pkg::POS_ADC_FILTER_EN];

  // test control: deliberately outside reset, contents survive any reset
  logic [6:0] test_r;
  logic [6:0] test_nxt;
  always_comb
  begin
    test_nxt = test_r;
    if (wr_test)
      test_nxt = REG_WDATA[cfr_pkg::TEST_MODE_W-1:0];
  end
  always_ff @(posedge SYS_CLK)
  begin
    test_r <= test_nxt;
  end

  // power steering
  logic pll_needed;
  logic [N_STAGES-1:0] stage_pwr_nxt;
  logic pll_pwr_nxt;
  logic filter_nxt;
  logic [6:0] test_out_nxt;
  logic [N_STAGES-1:0] stage_pwr_r;
  logic pll_pwr_r;
  logic filter_r;
  logic [6:0] test_out_r;

  assign pll_needed = (ADC_POWERED && ADC_RATE_44K_FAMILY) || (DAC_POWERED && DAC_RATE_44K_FAMILY);

  always_comb
  begin
    filter_nxt = adc_filter_bit;
    test_out_nxt = VENDOR_TEST_MODE ? test_r : 7'h00;
    stage_pwr_nxt = {N_STAGES{1'b1}};
    pll_pwr_nxt = 1'b1;
    unique case (cfr_pkg::cfr_low_power_e'(low_power_select))
      cfr_pkg::CFR_LP_NONE:
      begin
        stage_pwr_nxt = {N_STAGES{1'b1}};
        pll_pwr_nxt = 1'b1;
      end
      cfr_pkg::CFR_LP_CODEC:
      begin
        stage_pwr_nxt = INPUT_STAGE_USED;
        pll_pwr_nxt = 1'b1;
      end
      cfr_pkg::CFR_LP_PLL:
      begin
        stage_pwr_nxt = {N_STAGES{1'b1}};
        pll_pwr_nxt = pll_needed;
      end
      cfr_pkg::CFR_LP_BOTH:
      begin
        stage_pwr_nxt = INPUT_STAGE_USED;
        pll_pwr_nxt = pll_needed;
      end
    endcase
  end

  // power comes up fully on after reset, matching select 0
  always_ff @(posedge SYS_CLK)
  begin
    if (SRST)
    begin
      stage_pwr_r <= {N_STAGES{1'b1}};
      pll_pwr_r <= 1'b1;
      filter_r <= 1'b0;
      test_out_r <= 7'h00;
    end
    else
    begin
      stage_pwr_r <= stage_pwr_nxt;
      pll_pwr_r <= pll_pwr_nxt;
      filter_r <= filter_nxt;
      test_out_r <= test_out_nxt;
    end
  end

  assign INPUT_STAGE_POWER = stage_pwr_r;
  assign PLL_POWER = pll_pwr_r;
  assign ADC_FILTER_ENABLE = filter_r;
  assign TEST_MODE_FIELD = test_out_r;
  assign SHORT_FLAGS = fl.flags;

  // read path, answered one cycle after the request
  logic [15:0] rdata_r;
  logic [15:0] rdata_nxt;
  logic rvalid_r;
  logic rvalid_nxt;
  always_comb
  begin
    rvalid_nxt = REG_RD;
    rdata_nxt = rdata_r;
    if (REG_RD)
    begin
      unique case (REG_INDEX)
        cfr_pkg::IDX_FEAT_CTRL_TWO: rdata_nxt = feat_r;
        cfr_pkg::IDX_TEST_CTRL: rdata_nxt = {9'h000, test_r};
        cfr_pkg::IDX_SHORT_STATUS: rdata_nxt = {fl.flags[0], fl.flags[1], fl.flags[2], 13'h0000};
        cfr_pkg::IDX_VENDOR_ONE: rdata_nxt = VENDOR_ID_ONE;
        cfr_pkg::IDX_VENDOR_TWO: rdata_nxt = VENDOR_ID_TWO;
        default: rdata_nxt = 16'h0000;
      endcase
    end
  end
  always_ff @(posedge SYS_CLK)
  begin
    if (SRST)
    begin
      rdata_r <= 16'h0000;
      rvalid_r <= 1'b0;
    end
    else
    begin
      rdata_r <= rdata_nxt;
      rvalid_r <= rvalid_nxt;
    end
  end

  assign REG_RDATA = rdata_r;
  assign REG_RVALID = rvalid_r;

  default clocking cb @(posedge SYS_CLK);
  endclocking
  default disable iff (SRST);

  sequence left_clip_held;
    LEFT_CLIP_SIGNAL [*3];
  endsequence

  sequence right_clip_held;
    RIGHT_CLIP_SIGNAL [*3];
  endsequence

  sequence ground_clip_held;
    GROUND_CLIP_SIGNAL [*3];
  endsequence

  sequence left_clear_write;
    wr_short && REG_WDATA[cfr_pkg::POS_LEFT_SHORT] && !fl.set[0];
  endsequence

  a_left_flag_latch: assert property (left_clip_held |-> ##1 SHORT_FLAGS[0])
    else $error("left short flag not set after clip");

  a_right_flag_latch: assert property (right_clip_held |-> ##1 SHORT_FLAGS[1])
    else $error("right short flag not set after clip");

  a_ref_flag_latch: assert property (ground_clip_held |-> ##1 SHORT_FLAGS[2])
    else $error("reference short flag not set after clip");

  a_left_flag_clear: assert property (left_clear_write |=> !SHORT_FLAGS[0])
    else $error("left short flag not cleared by write one");

  a_ref_flag_hold: assert property (SHORT_FLAGS[2] && !fl.clr[2] |=> SHORT_FLAGS[2])
    else $error("reference short flag dropped without clear");

  a_zero_write_keeps: assert property (wr_short && !REG_WDATA[cfr_pkg::POS_LEFT_SHORT] && SHORT_FLAGS[0]
    |=> SHORT_FLAGS[0])
    else $error("zero write changed left short flag");

  a_pll_full_on: assert property (!low_power_select[1] |=> PLL_POWER)
    else $error("pll off while pll gating disabled");

  a_pll_gated: assert property (low_power_select[1] |=> PLL_POWER == $past(pll_needed))
    else $error("pll power does not follow converter rate demand");

  a_stage_gated: assert property (low_power_select[0] |=> INPUT_STAGE_POWER == $past(INPUT_STAGE_USED))
    else $error("input stage power does not follow usage");

  a_stage_full_on: assert property (!low_power_select[0] |=> &INPUT_STAGE_POWER)
    else $error("input stage gated while codec gating disabled");

  a_filter_follow: assert property (wr_feat
    |=> ##1 ADC_FILTER_ENABLE == $past(REG_WDATA[cfr_pkg::POS_ADC_FILTER_EN], 2))
    else $error("adc filter enable does not follow register");

  a_test_gated: assert property (!VENDOR_TEST_MODE |=> TEST_MODE_FIELD == 7'h00)
    else $error("test mode field active outside test mode");

  a_ident_read: assert property (REG_RD && REG_INDEX == cfr_pkg::IDX_VENDOR_ONE
    |=> REG_RVALID && REG_RDATA == VENDOR_ID_ONE)
    else $error("identification one read wrong");

  a_ident_two_read: assert property (REG_RD && REG_INDEX == cfr_pkg::IDX_VENDOR_TWO
    |=> REG_RVALID && REG_RDATA == VENDOR_ID_TWO)
    else $error("identification two read wrong");

  sequence status_read;
    REG_RD && REG_INDEX == cfr_pkg::IDX_SHORT_STATUS;
  endsequence

  a_status_reserved: assert property (status_read
    |=> REG_RDATA[12:0] == 13'h0000)
    else $error("short status reserved bits not zero");

  a_status_left_bit: assert property (status_read
    |=> REG_RDATA[cfr_pkg::POS_LEFT_SHORT] == $past(SHORT_FLAGS[0]))
    else $error("left short flag read at wrong position");

  a_status_right_bit: assert property (status_read
    |=> REG_RDATA[cfr_pkg::POS_RIGHT_SHORT] == $past(SHORT_FLAGS[1]))
    else $error("right short flag read at wrong position");

  a_status_ref_bit: assert property (status_read
    |=> REG_RDATA[cfr_pkg::POS_REF_SHORT] == $past(SHORT_FLAGS[2]))
    else $error("reference short flag read at wrong position");

endmodule
`default_nettype wire

// ==== placeholder_none.sv ====
`timescale 1ns/1ns
`default_nettype none
`default_nettype wire

// ==== cfr_host.sv ====
`timescale 1ns/1ns
`default_nettype none
module cfr_host
(
  input wire logic SYS_CLK,
  output logic [6:0] REG_INDEX,
  output logic REG_WR,
  output logic REG_RD,
  output logic [15:0] REG_WDATA,
  input wire logic [15:0] REG_RDATA,
  input wire logic REG_RVALID
);
  initial
  begin
    REG_INDEX = 7'h00;
    REG_WR = 1'b0;
    REG_RD = 1'b0;
    REG_WDATA = 16'h0000;
  end

  task automatic wr(input logic [6:0] idx, input logic [15:0] d);
    @(negedge SYS_CLK);
    REG_INDEX = idx;
    REG_WDATA = (idx == cfr_pkg::IDX_FEAT_CTRL_TWO) ? (d & ~16'hec07) : d;
    REG_WR = 1'b1;
    @(negedge SYS_CLK);
    REG_WR = 1'b0;
    // released data never keeps its last value
    REG_WDATA = ~REG_WDATA;
  endtask

  task automatic rd(input logic [6:0] idx, output logic [15:0] d);
    int n;
    n = 0;
    @(negedge SYS_CLK);
    REG_INDEX = idx;
    REG_RD = 1'b1;
    @(negedge SYS_CLK);
    REG_RD = 1'b0;
    while (REG_RVALID !== 1'b1 && n < 4)
    begin
      @(negedge SYS_CLK);
      n++;
    end
    // a missing answer comes back unknown so the compare fails
    d = (REG_RVALID === 1'b1) ? REG_RDATA : 16'hxxxx;
  endtask
endmodule
`default_nettype wire

// ==== codec_feature_test_clip_id_regs_test.sv ====
`timescale 1ns/1ns
`default_nettype none
module codec_feature_test_clip_id_regs_test;
  localparam logic [15:0] ID1 = 16'h1a2b; // arbitrary value
  localparam logic [15:0] ID2 = 16'h3c4d; // arbitrary value
  localparam logic [6:0] FC = cfr_pkg::IDX_FEAT_CTRL_TWO;
  localparam logic [6:0] TC = cfr_pkg::IDX_TEST_CTRL;
  localparam logic [6:0] SS = cfr_pkg::IDX_SHORT_STATUS;
  logic clk, srst, lc, rc, gc, vtm, ap, dp, ar, dr, wr, rd, rvalid, afe, pll;
  logic [3:0] used, stp;
  logic [6:0] idx, tmf;
  logic [15:0] wdata, rdata, v;
  logic [2:0] sf;
  int fails, total_checks;

  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  cfr_regs #(.N_STAGES(4), .VENDOR_ID_ONE(ID1), .VENDOR_ID_TWO(ID2)) DUT (
    .SYS_CLK(clk), .SRST(srst), .REG_INDEX(idx), .REG_WR(wr), .REG_RD(rd),
    .REG_WDATA(wdata), .REG_RDATA(rdata), .REG_RVALID(rvalid),
    .LEFT_CLIP_SIGNAL(lc), .RIGHT_CLIP_SIGNAL(rc), .GROUND_CLIP_SIGNAL(gc),
    .VENDOR_TEST_MODE(vtm), .INPUT_STAGE_USED(used), .ADC_POWERED(ap),
    .DAC_POWERED(dp), .ADC_RATE_44K_FAMILY(ar), .DAC_RATE_44K_FAMILY(dr),
    .ADC_FILTER_ENABLE(afe), .INPUT_STAGE_POWER(stp), .PLL_POWER(pll),
    .TEST_MODE_FIELD(tmf), .SHORT_FLAGS(sf));

  cfr_host host (.SYS_CLK(clk), .REG_INDEX(idx), .REG_WR(wr), .REG_RD(rd),
    .REG_WDATA(wdata), .REG_RDATA(rdata), .REG_RVALID(rvalid));

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      fails++;
    end
  endtask

  task automatic test_done;
    if (fails == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic do_reset;
    @(negedge clk);
    srst = 1'b1;
    repeat (16) @(negedge clk);
    srst = 1'b0;
  endtask

  task automatic t_after_reset;
    host.rd(SS, v);
    chk(v, 16'h0000);
    host.rd(cfr_pkg::IDX_VENDOR_ONE, v);
    chk(v, ID1);
    host.rd(cfr_pkg::IDX_VENDOR_TWO, v);
    chk(v, ID2);
    host.wr(cfr_pkg::IDX_VENDOR_ONE, 16'h0000);
    host.rd(cfr_pkg::IDX_VENDOR_ONE, v);
    chk(v, ID1);
    host.rd(7'h00, v);
    chk(v, 16'h0000);
    chk({15'h0, afe}, 16'h0000);
    chk({11'h0, pll, stp}, 16'h001f);
  endtask

  task automatic t_filter;
    host.wr(FC, 16'h1000);
    repeat (2) @(negedge clk);
    chk({15'h0, afe}, 16'h0001);
    host.rd(FC, v);
    chk(v, 16'h1000);
    host.wr(FC, 16'h0000);
    repeat (2) @(negedge clk);
    chk({15'h0, afe}, 16'h0000);
  endtask

  task automatic t_power;
    used = 4'h5;
    ap = 1'b1;
    ar = 1'b0;
    dp = 1'b0;
    dr = 1'b1;
    for (int s = 0; s < 4; s++)
    begin
      host.wr(FC, 16'(s) << 4);
      repeat (2) @(negedge clk);
      chk({11'h0, pll, stp}, {11'h0, ~s[1], s[0] ? 4'h5 : 4'hf});
    end
    dp = 1'b1;
    repeat (2) @(negedge clk);
    chk({11'h0, pll, stp}, 16'h0015);
    dp = 1'b0;
    ar = 1'b1;
    repeat (2) @(negedge clk);
    chk({11'h0, pll, stp}, 16'h0015);
    host.wr(FC, 16'h0000);
  endtask

  task automatic t_test_ctrl;
    host.wr(TC, 16'hffff);
    host.rd(TC, v);
    chk(v, 16'h007f);
    chk({9'h0, tmf}, 16'h0000);
    vtm = 1'b1;
    repeat (2) @(negedge clk);
    chk({9'h0, tmf}, 16'h007f);
    host.wr(TC, 16'h0055);
    do_reset();
    host.rd(TC, v);
    chk(v, 16'h0055);
    chk({9'h0, tmf}, 16'h0055);
    vtm = 1'b0;
  endtask

  task automatic t_clip;
    logic [15:0] m;
    for (int i = 0; i < 3; i++)
    begin
      m = 16'h8000 >> i;
      {gc, rc, lc} = 3'(1 << i);
      repeat (5) @(negedge clk);
      // clear lands on the last synchronised clip sample; set must win
      {gc, rc, lc} = 3'h0;
      host.wr(SS, 16'hffff);
      repeat (3) @(negedge clk);
      host.rd(SS, v);
      chk(v, m);
      chk({13'h0, sf}, 16'(1 << i));
      host.wr(SS, ~m);
      host.rd(SS, v);
      chk(v, m);
      host.wr(SS, m);
      host.rd(SS, v);
      chk(v, 16'h0000);
    end
  endtask

  initial
  begin
    fails = 0;
    total_checks = 0;
    srst = 1'b1;
    {lc, rc, gc, vtm, ap, dp, ar, dr} = 8'h00;
    used = 4'h0;
    repeat (16) @(negedge clk);
    srst = 1'b0;
    t_after_reset();
    t_filter();
    t_power();
    t_test_ctrl();
    t_clip();
    test_done();
  end
endmodule
`default_nettype wire
